// ### shared/asc_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the serial unit.
  Assumes an 8-bit APB byte address with one register per aligned word.
*/
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
// Register byte offsets
`define ASC_OFF_MODE 8'h00
`define ASC_OFF_CTRL 8'h04
`define ASC_OFF_DIV 8'h08
`define ASC_OFF_TDR 8'h0c
`define ASC_OFF_STAT 8'h10
`define ASC_OFF_RDR 8'h14
`define ASC_OFF_ISTAT 8'h18
`define ASC_OFF_ICLR 8'h1c
`define ASC_OFF_IEN 8'h20
// Status bit positions
`define ASC_ST_TX_BUFFER_EMPTY_FLAG 7
`define ASC_ST_RX_BUFFER_FULL_FLAG 6
`define ASC_ST_OVERRUN_ERROR_FLAG 5
`define ASC_ST_FER 4
// Control and mode bit positions
`define ASC_CT_TE 5
`define ASC_CT_RE 4
`define ASC_CT_CLOCK_ENABLE_HI 1
`define ASC_CT_CLOCK_ENABLE_LO 0
`define ASC_MD_SYNC 7
// Reset values and interrupt width
`define ASC_DIV_RST 8'h40
`define ASC_IRQ_W 3
// Oversampling: last tick of each 16-tick bit and the tick at mid bit
`define ASC_LAST_TICK 4'hf
`define ASC_MID_TICK 4'h7
`define ASC_LAST_BIT 3'h7
`endif

// ### shared/asc_pkg.sv
/*
  Types of the serial unit: control fields and state machine states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package asc_pkg;
  // Control register fields
  typedef struct packed {
    logic te;
    logic re;
    logic clock_enable_hi;
    logic clock_enable_lo;
  } asc_ctrl_type;
  // Transmitter states
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} asc_tx_state_type;
  // Receiver states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asc_rx_state_type;
endpackage

// ### verilog/asc_serial_unit.sv
/*
  Asynchronous serial unit with APB registers, buffer flags, clock select,
  bit-rate clock output, DMA hand-off and an interrupt output.
  Assumes rxd, sck_i, standby and the DMA strobes are synchronous to pclk.
*/
`include "asc_defs.svh"
module asc_serial_unit import asc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip standby
  input wire logic standby,
  // DMA side
  input wire logic dma_tx_wr,
  input wire logic [7:0] dma_tx_data,
  input wire logic dma_rx_rd,
  output logic [7:0] rx_data,
  // Serial line
  input wire logic rxd,
  output logic txd,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  // Interrupt
  output logic irq
);
  logic sync_mode; // Communication mode bit
  asc_ctrl_type ctrl; // Enables and clock selects
  logic [7:0] div; // Internal 16x tick divisor
  logic [7:0] tx_data_reg; // tx_data_reg
  logic tx_buffer_empty_flag; // tx_buffer_empty_flag
  logic rx_buffer_full_flag; // rx_buffer_full_flag
  logic overrun_error_flag; // overrun_error_flag
  logic framing_error_flag; // framing_error_flag
  logic [3:0] seen; // Flags read as one, armed for clearing
  logic [`ASC_IRQ_W-1:0] irq_stat; // Sticky events
  logic [`ASC_IRQ_W-1:0] irq_en; // Interrupt enables
  logic [7:0] div_cnt; // Divider count
  logic sck_q; // Previous external clock level
  asc_tx_state_type tx_state; // Transmitter state
  logic [3:0] tx_ph; // Tick within transmit bit
  logic [2:0] tx_bits; // Data bits sent
  logic [7:0] tx_shift_reg; // tx_shift_reg
  asc_rx_state_type rx_state; // Receiver state
  logic [3:0] rx_ph; // Tick within receive bit
  logic [2:0] rx_bits; // Data bits taken
  logic [7:0] rx_shift_reg; // rx_shift_reg
  logic rxd_q; // Line level at previous tick

  // Address decode used only for the error response; read mux and writes compare paddr themselves
  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {`ASC_OFF_MODE, `ASC_OFF_CTRL, `ASC_OFF_DIV, `ASC_OFF_TDR,
                       `ASC_OFF_STAT, `ASC_OFF_RDR, `ASC_OFF_ISTAT, `ASC_OFF_ICLR,
                       `ASC_OFF_IEN};
  endfunction

  wire apb_done = psel & penable & pready; // Transfer completes this edge
  wire wr_en = apb_done & pwrite;
  wire rd_stat = apb_done & ~pwrite & (paddr == `ASC_OFF_STAT);
  wire wr_stat = wr_en & (paddr == `ASC_OFF_STAT);
  wire [3:0] flags = {tx_buffer_empty_flag, rx_buffer_full_flag, overrun_error_flag, framing_error_flag};
  // Clear only a flag that was read as one and is now written zero
  wire [3:0] sw_clr = {4{wr_stat}} & seen & ~pwdata[7:4];

  // Clock select: external edge or internal divider
  wire int_tick = (div_cnt == 8'h00);
  wire ext_tick = sck_i & ~sck_q;
  wire tick = ctrl.clock_enable_hi ? ext_tick : int_tick;
  wire tx_run = ctrl.te & ~standby;
  wire rx_run = ctrl.re & ~standby;
  // Transmit data moves from buffer to shifter
  wire tx_load = tx_run & tick & (tx_state == TX_IDLE) & ~tx_buffer_empty_flag;
  // Stop bit sample at mid bit ends the frame
  wire rx_fin = rx_run & tick & (rx_state == RX_STOP) & (rx_ph == `ASC_LAST_TICK);
  wire rx_deliver = rx_fin & rxd & ~rx_buffer_full_flag;
  wire rx_overrun = rx_fin & rxd & rx_buffer_full_flag;
  wire rx_frame = rx_fin & ~rxd;

  // APB answer: ready in the first access cycle, data registered with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        unique case (paddr)
          `ASC_OFF_MODE: prdata[`ASC_MD_SYNC] <= sync_mode;
          `ASC_OFF_CTRL: begin
            prdata[`ASC_CT_TE] <= ctrl.te;
            prdata[`ASC_CT_RE] <= ctrl.re;
            prdata[`ASC_CT_CLOCK_ENABLE_HI] <= ctrl.clock_enable_hi;
            prdata[`ASC_CT_CLOCK_ENABLE_LO] <= ctrl.clock_enable_lo;
          end
          `ASC_OFF_DIV: prdata[7:0] <= div;
          `ASC_OFF_TDR: prdata[7:0] <= tx_data_reg;
          `ASC_OFF_STAT: prdata[7:4] <= flags;
          `ASC_OFF_RDR: prdata[7:0] <= rx_data;
          `ASC_OFF_ISTAT: prdata[`ASC_IRQ_W-1:0] <= irq_stat;
          `ASC_OFF_IEN: prdata[`ASC_IRQ_W-1:0] <= irq_en;
          // Clear register is write-only; unmapped reads zero
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software configuration; software must drop TE and RE before changing it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_mode <= 1'b0;
      ctrl <= '0;
      div <= `ASC_DIV_RST;
      irq_en <= '0;
    end else if (wr_en) begin
      if (paddr == `ASC_OFF_MODE) sync_mode <= pwdata[`ASC_MD_SYNC];
      if (paddr == `ASC_OFF_CTRL) begin
        ctrl.te <= pwdata[`ASC_CT_TE];
        ctrl.re <= pwdata[`ASC_CT_RE];
        ctrl.clock_enable_hi <= pwdata[`ASC_CT_CLOCK_ENABLE_HI];
        ctrl.clock_enable_lo <= pwdata[`ASC_CT_CLOCK_ENABLE_LO];
      end
      if (paddr == `ASC_OFF_DIV) div <= pwdata[7:0];
      if (paddr == `ASC_OFF_IEN) irq_en <= pwdata[`ASC_IRQ_W-1:0];
    end
  end

  // Transmit buffer: CPU or DMA may fill it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_data_reg <= 8'h00;
    else if (dma_tx_wr) tx_data_reg <= dma_tx_data;
    else if (wr_en & (paddr == `ASC_OFF_TDR)) tx_data_reg <= pwdata[7:0];
  end

  // Arming: a status read remembers which flags it saw set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= 4'h0;
    // Arm from the value returned, not from flags that may have moved since the setup
    else if (rd_stat) seen <= seen | prdata[7:4];
    else if (wr_stat) seen <= 4'h0;
  end

  // Transmit empty flag; setting causes win over clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_buffer_empty_flag <= 1'b1;
    else if (~tx_run | tx_load) tx_buffer_empty_flag <= 1'b1;
    else if (sw_clr[3] | dma_tx_wr) tx_buffer_empty_flag <= 1'b0;
  end

  // Receive full flag; a new frame wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_buffer_full_flag <= 1'b0;
    else if (standby) rx_buffer_full_flag <= 1'b0;
    else if (rx_deliver) rx_buffer_full_flag <= 1'b1;
    else if (sw_clr[2] | dma_rx_rd) rx_buffer_full_flag <= 1'b0;
  end

  // Error flags; disabling the receiver does not touch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      if (rx_overrun) overrun_error_flag <= 1'b1;
      else if (sw_clr[1]) overrun_error_flag <= 1'b0;
      if (rx_frame) framing_error_flag <= 1'b1;
      else if (sw_clr[0]) framing_error_flag <= 1'b0;
    end
  end

  // Receive data register changes only on a clean frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_data <= 8'h00;
    else if (rx_deliver) rx_data <= rx_shift_reg;
  end

  // Internal divider; an external clock is edge detected, it is already synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck_i;
      div_cnt <= int_tick ? div : div_cnt - 8'h01;
    end
  end

  // Transmitter: start, eight data bits LSB first, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      tx_ph <= 4'h0;
      tx_bits <= 3'h0;
      tx_shift_reg <= 8'h00;
      txd <= 1'b1;
    end else if (~tx_run) begin
      // Disable or standby drops the frame and clears the shifter
      tx_state <= TX_IDLE;
      tx_ph <= 4'h0;
      tx_bits <= 3'h0;
      tx_shift_reg <= 8'h00;
      txd <= 1'b1;
    end else if (tx_load) begin
      tx_shift_reg <= tx_data_reg;
      tx_state <= TX_START;
      tx_ph <= 4'h0;
      txd <= 1'b0;
    end else if (tick & (tx_state != TX_IDLE)) begin
      tx_ph <= tx_ph + 4'h1;
      if (tx_ph == `ASC_LAST_TICK) begin
        unique case (tx_state)
          TX_START: begin
            tx_state <= TX_DATA;
            tx_bits <= 3'h0;
            txd <= tx_shift_reg[0];
          end
          TX_DATA: begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bits <= tx_bits + 3'h1;
            if (tx_bits == `ASC_LAST_BIT) begin
              tx_state <= TX_STOP;
              txd <= 1'b1;
            end else begin
              txd <= tx_shift_reg[1];
            end
          end
          TX_STOP: tx_state <= TX_IDLE;
          TX_IDLE: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // Bit-rate clock: low first half, high second half, so it rises mid bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_o <= 1'b1;
      sck_oe <= 1'b0;
    end else begin
      sck_oe <= ~ctrl.clock_enable_hi & (sync_mode | ctrl.clock_enable_lo);
      if (~tx_run | (tx_state == TX_IDLE & ~tx_load)) sck_o <= 1'b1;
      else if (tx_load) sck_o <= 1'b0;
      // Held high over the end of the stop bit, so no runt low pulse trails a frame
      else if (tick) sck_o <= ((tx_ph >= `ASC_MID_TICK) & (tx_ph != `ASC_LAST_TICK))
                              | ((tx_state == TX_STOP) & (tx_ph == `ASC_LAST_TICK));
    end
  end

  // Receiver at 16x: falling edge starts, mid-bit check rejects glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_ph <= 4'h0;
      rx_bits <= 3'h0;
      rx_shift_reg <= 8'h00;
      rxd_q <= 1'b1;
    end else if (~rx_run) begin
      // Abort the frame only; data register and error flags are left as they are, standby clears the full flag
      rx_state <= RX_IDLE;
      rx_ph <= 4'h0;
      rxd_q <= 1'b1;
    end else if (tick) begin
      rxd_q <= rxd;
      rx_ph <= rx_ph + 4'h1;
      unique case (rx_state)
        RX_IDLE: begin
          rx_ph <= 4'h0;
          if (rxd_q & ~rxd) rx_state <= RX_START;
        end
        RX_START: if (rx_ph == `ASC_MID_TICK - 4'h1) begin
          // Restart phase at mid start bit so later samples land mid bit
          rx_ph <= 4'h0;
          rx_bits <= 3'h0;
          rx_state <= rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_ph == `ASC_LAST_TICK) begin
          rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
          rx_bits <= rx_bits + 3'h1;
          if (rx_bits == `ASC_LAST_BIT) rx_state <= RX_STOP;
        end
        RX_STOP: if (rx_ph == `ASC_LAST_TICK) rx_state <= RX_IDLE;
      endcase
    end
  end

  // Sticky events: transmit load, receive full, receive error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      // New events win over a clear in the same cycle
      irq_stat <= (irq_stat & ~({`ASC_IRQ_W{wr_en & (paddr == `ASC_OFF_ICLR)}}
                   & pwdata[`ASC_IRQ_W-1:0])) | {rx_overrun | rx_frame, rx_deliver, tx_load};
      irq <= |(irq_stat & irq_en);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tx_buffer_empty_flag_dma_clear: assert property (dma_tx_wr & tx_run & ~tx_load |=> ~tx_buffer_empty_flag)
    else $error("tx_buffer_empty_flag not cleared by dma write");
  a_tx_buffer_empty_flag_standby_set: assert property (standby |=> tx_buffer_empty_flag)
    else $error("tx_buffer_empty_flag not set in standby");
  a_rx_buffer_full_flag_dma_clear: assert property (dma_rx_rd & ~rx_deliver & ~standby |=> ~rx_buffer_full_flag)
    else $error("rx_buffer_full_flag not cleared by dma read");
  a_rx_buffer_full_flag_frame_set: assert property (rx_deliver |=> rx_buffer_full_flag & (rx_data == $past(rx_shift_reg)))
    else $error("clean frame not delivered");
  a_error_keeps_data: assert property (rx_frame |=> $stable(rx_data))
    else $error("receive error changed data");
  a_overrun_drop: assert property (rx_overrun & ~dma_rx_rd & ~sw_clr[2]
                                   |=> overrun_error_flag & rx_buffer_full_flag & $stable(rx_data))
    else $error("overrun not flagged or data lost");
  a_sck_drive_sel: assert property (##1 sck_oe == $past(~ctrl.clock_enable_hi & (sync_mode | ctrl.clock_enable_lo)))
    else $error("clock pin drive does not match select");
  a_sck_mid_bit: assert property ($rose(sck_o) & (tx_state != TX_IDLE) |-> tx_ph == 4'h8)
    else $error("bit clock rising off centre");
  a_te_off_reinit: assert property (~ctrl.te |=> tx_buffer_empty_flag & txd & tx_shift_reg == 8'h00)
    else $error("transmitter not reinitialised");
  a_re_off_keep: assert property (~ctrl.re |=> $stable(rx_data) & ~rx_deliver)
    else $error("receive data changed while disabled");
  a_false_start: assert property (rx_run & tick & rx_state == RX_START & rx_ph == 4'h6 & rxd
                                  |=> rx_state == RX_IDLE)
    else $error("glitch accepted as start bit");

  c_deliver: cover property (rx_deliver);
  c_overrun: cover property (rx_overrun);
  c_frame: cover property (rx_frame);
  c_tx_two: cover property (tx_load ##[1:400] tx_load);
endmodule

// ### test/asc_line_peer.sv
/*
  Far end of the serial line: sends frames on rxd, listens on txd, runs a 16x clock.
  Assumes the unit ticks every pclk (divider 0) or on each sck_i rise (every two pclk).
*/
module asc_line_peer (
  // Clock
  input wire logic clk,
  // Line from the unit
  input wire logic txd,
  // Line and clock to the unit
  output logic rxd,
  output logic sck_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cyc = 16; // Pclk cycles per bit, set by the bench to match the tick source
  int n_got = 0; // Frames heard so far
  logic [7:0] got; // Last byte heard
  initial begin
    rxd = 1'b1;
    sck_i = 1'b0;
  end
  // Free-running 16x clock; never stopped, even between frames
  always @(posedge clk) begin
    sck_i <= ~sck_i;
  end
  // One 8N1 frame, LSB first; a zero stop bit makes a framing fault on purpose
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // Low pulse shorter than half a bit; the receiver must not take it as a start bit
  task automatic glitch(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
  endtask
  // Listener: from the start edge, sample each data bit at its middle
  initial forever begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      got[i] = txd;
    end
    n_got++;
  end
endmodule

// ### test/testbench.sv
/*
  Self-checking bench: APB register tasks, DMA strobes and a line peer.
  Assumes the unit answers each APB access within 50 access cycles.
*/
`include "asc_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, standby, dma_tx_wr, dma_rx_rd;
  logic [7:0] paddr, dma_tx_data, rx_data;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, rxd, txd, sck_i, sck_o, sck_oe, irq, ev;
  int n_mismatch = 0; // Mismatches seen
  int cmp_count = 0; // Comparisons made
  int n0;
  time t0;
  asc_serial_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby(standby), .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data),
    .dma_rx_rd(dma_rx_rd), .rx_data(rx_data), .rxd(rxd), .txd(txd), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe(sck_oe), .irq(irq));
  asc_line_peer peer (.clk(pclk), .txd(txd), .rxd(rxd), .sck_i(sck_i));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; two idle edges after it let registered side effects settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A transfer that never completes counts as a mismatch
    if (pready !== 1'b1) n_mismatch++;
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask
  task automatic dma(input logic [7:0] b);
    dma_tx_wr <= 1'b1;
    dma_tx_data <= b;
    @(posedge pclk) dma_tx_wr <= 1'b0;
    @(posedge pclk);
  endtask
  // Bounded wait for the peer to hear k frames
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (peer.n_got < k && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("frames heard", peer.n_got, k);
  endtask
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    {presetn, psel, penable, pwrite, standby, dma_tx_wr, dma_rx_rd} = '0;
    {paddr, dma_tx_data, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ASC_OFF_STAT, 32'h80, "status after reset");
    rd(`ASC_OFF_DIV, 32'h40, "divider after reset");
    rd(8'h40, 32'h0, "unmapped read");
    chk("unmapped error", ev, 1'b1);
    wr(`ASC_OFF_DIV, 32'h0);
    wr(`ASC_OFF_IEN, 32'h7);
    wr(`ASC_OFF_CTRL, 32'h31);
    chk("clock drive", sck_oe, 1'b1);
    // DMA path: second byte waits behind a busy shifter, so the flag stays low
    dma(8'h5a);
    @(negedge txd);
    t0 = $time;
    @(posedge sck_o);
    chk("clock phase", 32'(($time - t0) / 10), 32'd8);
    dma(8'hc3);
    rd(`ASC_OFF_STAT, 32'h00, "status tx busy");
    wait_got(1);
    chk("tx byte 1", peer.got, 8'h5a);
    wait_got(2);
    chk("tx byte 2", peer.got, 8'hc3);
    // CPU path: a data write alone does not start; read-then-write-0 does
    wr(`ASC_OFF_TDR, 32'h96);
    rd(`ASC_OFF_STAT, 32'h80, "status cpu write");
    wr(`ASC_OFF_STAT, 32'h0);
    wait_got(3);
    chk("tx byte 3", peer.got, 8'h96);
    chk("irq tx", irq, 1'b1);
    wr(`ASC_OFF_ICLR, 32'h7);
    chk("irq cleared", irq, 1'b0);
    // Transmit disable in mid-frame with a byte pending
    dma(8'h11);
    dma(8'h22);
    wr(`ASC_OFF_CTRL, 32'h11);
    rd(`ASC_OFF_STAT, 32'h80, "status tx off");
    chk("line after tx off", txd, 1'b1);
    wr(`ASC_OFF_CTRL, 32'h31);
    // Receive, overrun, framing fault, receive disable
    peer.send(8'ha5, 1'b1);
    rd(`ASC_OFF_STAT, 32'hc0, "status rx");
    rd(`ASC_OFF_RDR, 32'ha5, "rx data");
    chk("rx data pins", rx_data, 8'ha5);
    peer.send(8'h3c, 1'b1);
    rd(`ASC_OFF_STAT, 32'he0, "status overrun");
    rd(`ASC_OFF_RDR, 32'ha5, "rx data overrun");
    peer.send(8'h77, 1'b0);
    rd(`ASC_OFF_STAT, 32'hf0, "status framing");
    rd(`ASC_OFF_RDR, 32'ha5, "rx data framing");
    wr(`ASC_OFF_CTRL, 32'h21);
    rd(`ASC_OFF_STAT, 32'hf0, "status rx off");
    rd(`ASC_OFF_RDR, 32'ha5, "rx data rx off");
    dma_rx_rd <= 1'b1;
    @(posedge pclk) dma_rx_rd <= 1'b0;
    @(posedge pclk);
    rd(`ASC_OFF_STAT, 32'hb0, "status dma read");
    wr(`ASC_OFF_CTRL, 32'h31);
    peer.send(8'h0f, 1'b1);
    rd(`ASC_OFF_STAT, 32'hf0, "status rx again");
    standby <= 1'b1;
    repeat (2) @(posedge pclk);
    standby <= 1'b0;
    rd(`ASC_OFF_STAT, 32'hb0, "status standby");
    peer.send(8'he1, 1'b1);
    rd(`ASC_OFF_STAT, 32'hf0, "status before clear");
    wr(`ASC_OFF_STAT, 32'hb0);
    rd(`ASC_OFF_STAT, 32'hb0, "status sw clear");
    chk("rx data pins 2", rx_data, 8'he1);
    // A short low pulse on the line must not start a frame
    peer.glitch(4);
    repeat (160) @(posedge pclk);
    rd(`ASC_OFF_STAT, 32'hb0, "status after glitch");
    // Interrupt masking and clearing
    chk("irq rx", irq, 1'b1);
    wr(`ASC_OFF_IEN, 32'h0);
    chk("irq masked", irq, 1'b0);
    wr(`ASC_OFF_ICLR, 32'h7);
    rd(`ASC_OFF_ISTAT, 32'h0, "event status cleared");
    wr(`ASC_OFF_IEN, 32'h7);
    chk("irq after clear", irq, 1'b0);
    // External 16x clock on sck_i, both directions
    wr(`ASC_OFF_CTRL, 32'h0);
    wr(`ASC_OFF_CTRL, 32'h32);
    chk("clock released", sck_oe, 1'b0);
    peer.bit_cyc = 32;
    n0 = peer.n_got;
    dma(8'h81);
    wait_got(n0 + 1);
    chk("tx byte ext clock", peer.got, 8'h81);
    peer.send(8'h69, 1'b1);
    rd(`ASC_OFF_RDR, 32'h69, "rx data ext clock");
    complete_run;
  end
endmodule
